/* src/byte_lane_steer.sv */
// Byte lane steering for 8, 16 and 32 bit accesses, little-endian.
// Purely combinational; the caller registers everything it drives out.
`timescale 1ns/1ps

module byte_lane_steer
    import memory_map_pkg::*;
(
    input  wire logic [1:0]  size,      // Access size code
    input  wire logic [1:0]  addr_lo,   // Low address bits
    input  wire logic [31:0] wdata,     // Write value in low bits
    input  wire logic [31:0] rword,     // Raw word from the target
    output logic      [3:0]  byte_en,   // Lanes touched
    output logic      [31:0] wlanes,    // Write value on its lanes
    output logic      [31:0] rdata      // Read value moved to low bits
);

    logic [4:0]  shift;
    logic [31:0] shifted;

    // Lowest address maps to lane 0, so the shift is eight times the byte offset
    always_comb
    begin
        shift   = 5'h00;
        byte_en = 4'h0;
        wlanes  = 32'h0000_0000;
        rdata   = 32'h0000_0000;
        case (size)
            SIZE_BYTE:
            begin
                shift   = {addr_lo, 3'b000};
                byte_en = 4'h1 << addr_lo;
                wlanes  = {4{wdata[7:0]}};
            end
            SIZE_HALF:
            begin
                // Halfwords ignore address bit 0
                shift   = {addr_lo[1], 4'h0};
                byte_en = addr_lo[1] ? 4'hC : 4'h3;
                wlanes  = {2{wdata[15:0]}};
            end
            default:
            begin
                shift   = 5'h00;
                byte_en = 4'hF;
                wlanes  = wdata;
            end
        endcase
        shifted = rword >> shift;
        case (size)
            SIZE_BYTE: rdata = {24'h00_0000, shifted[7:0]};
            SIZE_HALF: rdata = {16'h0000, shifted[15:0]};
            default:   rdata = shifted;
        endcase
    end

endmodule : byte_lane_steer

/* src/memory_map_pkg.sv */
// Package for the memory map decoder: region bases, spans, the remap
// control location, access size codes and the decode target type.
// Assumes a single 32-bit byte-addressed bus and one clock domain.
package memory_map_pkg;

    // Bus widths
    localparam int unsigned ADDR_W        = 32;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned FLASH_W       = 16;
    localparam int unsigned SRAM_IDX_W    = 11;
    localparam int unsigned FLASH_IDX_W   = 15;
    localparam int unsigned CSR_OFF_W     = 16;

    // Access size codes on bus_size
    localparam logic [1:0] SIZE_BYTE      = 2'h0;
    localparam logic [1:0] SIZE_HALF      = 2'h1;
    localparam logic [1:0] SIZE_WORD      = 2'h2;

    // Region at address zero: flash mirror or SRAM
    localparam logic [31:0] ZERO_BASE     = 32'h0000_0000;
    localparam logic [31:0] ZERO_SPAN     = 32'h0001_0000;
    localparam logic [31:0] FAST_IRQ_VEC  = 32'h0000_001C;

    // Storage blocks at their own fixed regions
    localparam logic [31:0] SRAM_BASE     = 32'h0001_0000;
    localparam logic [31:0] SRAM_SPAN     = 32'h0000_2000;
    localparam int unsigned SRAM_WORDS    = 2048;
    localparam logic [31:0] FLASH_BASE    = 32'h0008_0000;
    localparam logic [31:0] FLASH_SPAN    = 32'h0001_0000;
    localparam logic [31:0] FLASH_USER    = 32'h0000_F800;

    // Register space: top two pages of the address space
    localparam logic [31:0] CSR_PAGE      = 32'h0000_8000;
    localparam logic [31:0] CSR_SPAN      = 32'h0001_0000;
    localparam logic [31:0] CSR_BASE      = 32'hFFFF_0000;

    // Remap control register, bit 0 set selects flash at zero
    localparam logic [31:0] REMAP_ADDR    = 32'hFFFF_0220;
    localparam logic        REMAP_RESET   = 1'b1;

    // Where a decoded access goes
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_SRAM,
        TGT_FLASH,
        TGT_REMAP,
        TGT_CSR
    } target_e;

endpackage : memory_map_pkg

/* src/memory_map_remap_decoder.sv */
// Address decoder for the shared instruction and data bus: SRAM, flash,
// register space and the remap control bit in one linear space.
// Assumes SRAM, flash and register ports with one cycle of read latency
// on this same clock, and a core that holds bus_req until bus_ready.
`timescale 1ns/1ps

module memory_map_remap_decoder
    import memory_map_pkg::*;
(
    input  wire logic        clk,          // System clock
    input  wire logic        rst_n,        // Async reset, active low
    input  wire logic        bus_req,      // Access request, held
    input  wire logic        bus_write,    // 1 write, 0 read
    input  wire logic [1:0]  bus_size,     // Byte, half or word
    input  wire logic [31:0] bus_addr,     // Byte address
    input  wire logic [31:0] bus_wdata,    // Write data in low bits
    output logic      [31:0] bus_rdata,    // Read data in low bits
    output logic             bus_ready,    // Access complete pulse
    output logic             bus_fault,    // Unmapped or refused
    output logic             remap_flash,  // 1 flash at zero, 0 SRAM
    output logic             sram_sel,     // SRAM strobe
    output logic             sram_we,      // SRAM write
    output logic      [3:0]  sram_be,      // SRAM byte enables
    output logic      [10:0] sram_addr,    // SRAM word index
    output logic      [31:0] sram_wdata,   // SRAM write word
    input  wire logic [31:0] sram_rdata,   // SRAM read word
    output logic             flash_sel,    // Flash strobe
    output logic             flash_we,     // Flash write
    output logic      [1:0]  flash_be,     // Flash byte enables
    output logic      [14:0] flash_addr,   // Flash halfword index
    output logic      [15:0] flash_wdata,  // Flash write halfword
    input  wire logic [15:0] flash_rdata,  // Flash read halfword
    output logic             csr_sel,      // Register space strobe
    output logic             csr_we,       // Register space write
    output logic      [3:0]  csr_be,       // Register byte enables
    output logic      [15:0] csr_addr,     // Offset in register space
    output logic      [31:0] csr_wdata,    // Register write word
    input  wire logic [31:0] csr_rdata     // Register read word
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_ACCESS,
        ST_CAPTURE,
        ST_DONE
    } state_e;

    state_e      state_reg,   state_next;
    target_e     tgt_reg,     tgt_next;
    target_e     tgt_dec;
    logic        write_reg,   write_next;
    logic [1:0]  size_reg,    size_next;
    logic [15:0] off_reg,     off_next;
    logic [31:0] wdata_reg,   wdata_next;
    logic        phase_reg,   phase_next;
    logic [15:0] flo_reg,     flo_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic        fault_reg,   fault_next;
    logic        remap_reg,   remap_next;
    logic        ssel_reg,    ssel_next;
    logic        swe_reg,     swe_next;
    logic [3:0]  sbe_reg,     sbe_next;
    logic [10:0] saddr_reg,   saddr_next;
    logic [31:0] swd_reg,     swd_next;
    logic        fsel_reg,    fsel_next;
    logic        fwe_reg,     fwe_next;
    logic [1:0]  fbe_reg,     fbe_next;
    logic [14:0] faddr_reg,   faddr_next;
    logic [15:0] fwd_reg,     fwd_next;
    logic        msel_reg,    msel_next;
    logic        mwe_reg,     mwe_next;
    logic [3:0]  mbe_reg,     mbe_next;
    logic [15:0] maddr_reg,   maddr_next;
    logic [31:0] mwd_reg,     mwd_next;
    logic [3:0]  lane_be;
    logic [31:0] lane_wd;
    logic [31:0] lane_rd;
    logic [31:0] raw_word;
    logic        word_acc;

    function automatic logic in_region(input logic [31:0] a,
                                       input logic [31:0] base,
                                       input logic [31:0] span);
        in_region = (a >= base) && ((a - base) < span);
    endfunction : in_region

    // Decode of the live bus address into one target
    always_comb
    begin
        tgt_dec = TGT_NONE;
        if (in_region(bus_addr, ZERO_BASE, ZERO_SPAN))
        begin
            // Vectors, 0x1C included, come from whichever block is here
            if (remap_reg)
                tgt_dec = TGT_FLASH;
            else if (bus_addr < SRAM_SPAN)
                tgt_dec = TGT_SRAM;
        end
        else if (in_region(bus_addr, SRAM_BASE, SRAM_SPAN))
            tgt_dec = TGT_SRAM;
        else if (in_region(bus_addr, FLASH_BASE, FLASH_SPAN))
            tgt_dec = TGT_FLASH;
        else if (bus_addr[31:2] == REMAP_ADDR[31:2])
            tgt_dec = TGT_REMAP;
        else if (in_region(bus_addr, CSR_BASE, CSR_SPAN))
            tgt_dec = TGT_CSR;
    end

    // Lane placement of write data and extraction of read data
    byte_lane_steer u_lanes (
        .size    (size_reg),
        .addr_lo (off_reg[1:0]),
        .wdata   (wdata_reg),
        .rword   (raw_word),
        .byte_en (lane_be),
        .wlanes  (lane_wd),
        .rdata   (lane_rd)
    );

    assign word_acc = (size_reg == SIZE_WORD);

    // Raw word seen by the lane logic while a read is captured
    always_comb
    begin
        raw_word = 32'h0000_0000;
        case (tgt_reg)
            TGT_SRAM:  raw_word = sram_rdata;
            TGT_CSR:   raw_word = csr_rdata;
            TGT_REMAP: raw_word = {31'h0000_0000, remap_reg};
            TGT_FLASH:
            begin
                // Lower halfword first, so it lands in the low lanes
                if (word_acc)
                    raw_word = {flash_rdata, flo_reg};
                else if (off_reg[1])
                    raw_word = {flash_rdata, 16'h0000};
                else
                    raw_word = {16'h0000, flash_rdata};
            end
            default:   raw_word = 32'h0000_0000;
        endcase
    end

    // Sequencer: one request at a time, data and fault shown with ready
    always_comb
    begin
        state_next = state_reg;
        tgt_next   = tgt_reg;
        write_next = write_reg;
        size_next  = size_reg;
        off_next   = off_reg;
        wdata_next = wdata_reg;
        phase_next = phase_reg;
        flo_next   = flo_reg;
        rdata_next = rdata_reg;
        fault_next = fault_reg;
        remap_next = remap_reg;
        ssel_next  = 1'b0;
        swe_next   = swe_reg;
        sbe_next   = sbe_reg;
        saddr_next = saddr_reg;
        swd_next   = swd_reg;
        fsel_next  = 1'b0;
        fwe_next   = fwe_reg;
        fbe_next   = fbe_reg;
        faddr_next = faddr_reg;
        fwd_next   = fwd_reg;
        msel_next  = 1'b0;
        mwe_next   = mwe_reg;
        mbe_next   = mbe_reg;
        maddr_next = maddr_reg;
        mwd_next   = mwd_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (bus_req)
                begin
                    tgt_next   = tgt_dec;
                    write_next = bus_write;
                    size_next  = bus_size;
                    off_next   = bus_addr[15:0];
                    wdata_next = bus_wdata;
                    phase_next = 1'b0;
                    fault_next = 1'b0;
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE:
            begin
                state_next = ST_ACCESS;
                case (tgt_reg)
                    TGT_SRAM:
                    begin
                        ssel_next  = 1'b1;
                        swe_next   = write_reg;
                        sbe_next   = lane_be;
                        saddr_next = off_reg[12:2];
                        swd_next   = lane_wd;
                    end
                    TGT_FLASH:
                    begin
                        // Boot page refuses writes, reads stay open
                        if (write_reg && ({16'h0000, off_reg} >= FLASH_USER))
                        begin
                            fault_next = 1'b1;
                            state_next = ST_DONE;
                        end
                        else
                        begin
                            fsel_next = 1'b1;
                            fwe_next  = write_reg;
                            if (word_acc)
                            begin
                                faddr_next = {off_reg[15:2], phase_reg};
                                fbe_next   = 2'h3;
                                fwd_next   = phase_reg ?
                                             wdata_reg[31:16] :
                                             wdata_reg[15:0];
                            end
                            else
                            begin
                                faddr_next = off_reg[15:1];
                                fbe_next   = off_reg[1] ?
                                             lane_be[3:2] : lane_be[1:0];
                                fwd_next   = off_reg[1] ?
                                             lane_wd[31:16] :
                                             lane_wd[15:0];
                            end
                        end
                    end
                    TGT_CSR:
                    begin
                        msel_next  = 1'b1;
                        mwe_next   = write_reg;
                        mbe_next   = lane_be;
                        maddr_next = off_reg;
                        mwd_next   = lane_wd;
                    end
                    TGT_REMAP:
                    begin
                        // Only the lane holding bit 0 may change it
                        if (write_reg && lane_be[0])
                            remap_next = lane_wd[0];
                    end
                    default:
                    begin
                        fault_next = 1'b0; // Flagged at capture
                    end
                endcase
            end
            ST_ACCESS:
            begin
                state_next = ST_CAPTURE;
            end
            ST_CAPTURE:
            begin
                if ((tgt_reg == TGT_FLASH) && word_acc && !phase_reg)
                begin
                    // First half of a word, fetch the upper halfword next
                    flo_next   = flash_rdata;
                    phase_next = 1'b1;
                    state_next = ST_ISSUE;
                end
                else
                begin
                    rdata_next = write_reg ? 32'h0000_0000 : lane_rd;
                    fault_next = (tgt_reg == TGT_NONE);
                    state_next = ST_DONE;
                end
            end
            ST_DONE:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Registers; remap resets to flash so the core boots from it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            tgt_reg   <= TGT_NONE;
            write_reg <= 1'b0;
            size_reg  <= SIZE_BYTE;
            off_reg   <= 16'h0000;
            wdata_reg <= 32'h0000_0000;
            phase_reg <= 1'b0;
            flo_reg   <= 16'h0000;
            rdata_reg <= 32'h0000_0000;
            fault_reg <= 1'b0;
            remap_reg <= REMAP_RESET;
            ssel_reg  <= 1'b0;
            swe_reg   <= 1'b0;
            sbe_reg   <= 4'h0;
            saddr_reg <= 11'h000;
            swd_reg   <= 32'h0000_0000;
            fsel_reg  <= 1'b0;
            fwe_reg   <= 1'b0;
            fbe_reg   <= 2'h0;
            faddr_reg <= 15'h0000;
            fwd_reg   <= 16'h0000;
            msel_reg  <= 1'b0;
            mwe_reg   <= 1'b0;
            mbe_reg   <= 4'h0;
            maddr_reg <= 16'h0000;
            mwd_reg   <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            tgt_reg   <= tgt_next;
            write_reg <= write_next;
            size_reg  <= size_next;
            off_reg   <= off_next;
            wdata_reg <= wdata_next;
            phase_reg <= phase_next;
            flo_reg   <= flo_next;
            rdata_reg <= rdata_next;
            fault_reg <= fault_next;
            remap_reg <= remap_next;
            ssel_reg  <= ssel_next;
            swe_reg   <= swe_next;
            sbe_reg   <= sbe_next;
            saddr_reg <= saddr_next;
            swd_reg   <= swd_next;
            fsel_reg  <= fsel_next;
            fwe_reg   <= fwe_next;
            fbe_reg   <= fbe_next;
            faddr_reg <= faddr_next;
            fwd_reg   <= fwd_next;
            msel_reg  <= msel_next;
            mwe_reg   <= mwe_next;
            mbe_reg   <= mbe_next;
            maddr_reg <= maddr_next;
            mwd_reg   <= mwd_next;
        end
    end

    // Outputs; ready is decoded from state, everything else is a flop
    assign bus_ready   = (state_reg == ST_DONE);
    assign bus_rdata   = rdata_reg;
    assign bus_fault   = fault_reg;
    assign remap_flash = remap_reg;
    assign sram_sel    = ssel_reg;
    assign sram_we     = swe_reg;
    assign sram_be     = sbe_reg;
    assign sram_addr   = saddr_reg;
    assign sram_wdata  = swd_reg;
    assign flash_sel   = fsel_reg;
    assign flash_we    = fwe_reg;
    assign flash_be    = fbe_reg;
    assign flash_addr  = faddr_reg;
    assign flash_wdata = fwd_reg;
    assign csr_sel     = msel_reg;
    assign csr_we      = mwe_reg;
    assign csr_be      = mbe_reg;
    assign csr_addr    = maddr_reg;
    assign csr_wdata   = mwd_reg;

endmodule : memory_map_remap_decoder

/* tb/mem_far_side.sv */
// Far-side memories: SRAM words, flash halfwords, register words.
// Assumes one-cycle read latency after each strobe; no wait states.
`timescale 1ns/1ps

module mem_far_side
(
    input  wire logic        clk,         // System clock
    input  wire logic        sram_sel,    // SRAM strobe
    input  wire logic        sram_we,     // SRAM write
    input  wire logic [3:0]  sram_be,     // SRAM lanes
    input  wire logic [10:0] sram_addr,   // SRAM word index
    input  wire logic [31:0] sram_wdata,  // SRAM write word
    output logic      [31:0] sram_rdata,  // SRAM read word
    input  wire logic        flash_sel,   // Flash strobe
    input  wire logic        flash_we,    // Flash write
    input  wire logic [1:0]  flash_be,    // Flash lanes
    input  wire logic [14:0] flash_addr,  // Flash halfword index
    input  wire logic [15:0] flash_wdata, // Flash write halfword
    output logic      [15:0] flash_rdata, // Flash read halfword
    input  wire logic        csr_sel,     // Register strobe
    input  wire logic        csr_we,      // Register write
    input  wire logic [3:0]  csr_be,      // Register lanes
    input  wire logic [15:0] csr_addr,    // Register offset
    input  wire logic [31:0] csr_wdata,   // Register write word
    output logic      [31:0] csr_rdata    // Register read word
);
    logic [31:0] sram_mem [2048];
    logic [15:0] flash_mem [32768];
    logic [31:0] csr_mem [16384];

    initial
    begin
        sram_rdata = '0;
        flash_rdata = '0;
        csr_rdata = '0;
    end

    // Idle read lines toggle so stale data is never mistaken for valid
    always @(posedge clk)
    begin
        sram_rdata <= sram_sel ? sram_mem[sram_addr] : ~sram_rdata;
        flash_rdata <= flash_sel ? flash_mem[flash_addr]
                                 : ~flash_rdata;
        csr_rdata <= csr_sel ? csr_mem[csr_addr[15:2]] : ~csr_rdata;
        for (int i = 0; i < 4; i++)
        begin
            if (sram_sel && sram_we && sram_be[i])
                sram_mem[sram_addr][8*i +: 8] <= sram_wdata[8*i +: 8];
            if (csr_sel && csr_we && csr_be[i])
                csr_mem[csr_addr[15:2]][8*i +: 8] <= csr_wdata[8*i +: 8];
            if (i < 2 && flash_sel && flash_we && flash_be[i])
                flash_mem[flash_addr][8*i +: 8] <= flash_wdata[8*i +: 8];
        end
    end
endmodule : mem_far_side

/* tb/memory_map_checker.sv */
// Checker for the memory map decoder: timing and steering relations.
// Assumes a bind onto the decoder top; one clock, async active-low reset.
`timescale 1ns/1ps

module memory_map_checker
    import memory_map_pkg::*;
(
    input wire logic        clk,         // System clock
    input wire logic        rst_n,       // Async reset, active low
    input wire logic        bus_req,     // Access request
    input wire logic        bus_write,   // Write flag
    input wire logic [1:0]  bus_size,    // Access size code
    input wire logic [31:0] bus_addr,    // Byte address
    input wire logic        bus_ready,   // Completion pulse
    input wire logic        bus_fault,   // Refused or unmapped
    input wire logic        remap_flash, // Flash at zero
    input wire logic        sram_sel,    // SRAM strobe
    input wire logic        sram_we,     // SRAM write
    input wire logic [10:0] sram_addr,   // SRAM word index
    input wire logic        flash_sel,   // Flash strobe
    input wire logic        flash_we,    // Flash write
    input wire logic [14:0] flash_addr,  // Flash halfword index
    input wire logic        csr_sel,     // Register strobe
    input wire logic        csr_we,      // Register write
    input wire logic [15:0] csr_addr     // Register offset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Completion and target selection
    a_ready_pulse: assert property (bus_ready |=> !bus_ready)
        else $error("bus_ready held past one cycle");
    a_strobe_in_req: assert property (
        (sram_sel || flash_sel || csr_sel) |-> bus_req)
        else $error("memory strobe without a request");
    a_one_target: assert property (
        $onehot0({sram_sel, flash_sel, csr_sel}))
        else $error("two targets strobed at once");
    // Read data from SRAM and registers comes back two cycles on
    a_sram_read_lat: assert property (
        sram_sel && !sram_we |-> ##2 bus_ready)
        else $error("SRAM read completion late or early");
    a_csr_read_lat: assert property (
        csr_sel && !csr_we |-> ##2 bus_ready)
        else $error("register read completion late or early");
    // Index and offset follow the byte address
    a_sram_index: assert property (
        sram_sel |-> sram_addr == bus_addr[12:2])
        else $error("SRAM word index wrong");
    a_flash_index: assert property (
        flash_sel |-> flash_addr[14:1] == bus_addr[15:2])
        else $error("flash halfword index wrong");
    a_csr_offset: assert property (
        csr_sel |-> csr_addr[15:2] == bus_addr[15:2])
        else $error("register offset wrong");
    // A word from flash takes low then high halfword
    a_flash_pair: assert property (
        flash_sel && !flash_we && !flash_addr[0] && bus_size == SIZE_WORD
        |-> ##3 (flash_sel && flash_addr[0]))
        else $error("flash high halfword not fetched");
    a_boot_locked: assert property (
        flash_sel && flash_we |-> flash_addr < 15'h7C00)
        else $error("write reached the boot page");
    a_fault_ready: assert property ($rose(bus_fault) |-> bus_ready)
        else $error("fault raised outside completion");
    a_remap_cause: assert property (
        $changed(remap_flash) |-> $past(bus_req) && $past(bus_write)
        && bus_addr == REMAP_ADDR)
        else $error("remap bit moved without a write");

    // Main scenarios reached
    c_remap_clear: cover property ($fell(remap_flash));
    c_flash_pair: cover property (flash_sel ##3 flash_sel);
    c_fault: cover property (bus_ready && bus_fault);
endmodule : memory_map_checker

/* tb/memory_map_remap_decoder_test.sv */
// Self-checking bench for the memory map decoder and its remap bit.
// Assumes the far-side memory model and the bound checker alongside.
`timescale 1ns/1ps

module memory_map_remap_decoder_test;
    import memory_map_pkg::*;
    logic clk = 0, rst_n = 0, bus_req = 0, bus_write = 0;
    logic [1:0] bus_size = '0;
    logic [31:0] bus_addr = '0, bus_wdata = '0, bus_rdata, sram_rdata;
    logic [31:0] sram_wdata, csr_wdata, csr_rdata, rd;
    logic bus_ready, bus_fault, remap_flash, sram_sel, sram_we, flt;
    logic flash_sel, flash_we, csr_sel, csr_we;
    logic [3:0] sram_be, csr_be;
    logic [1:0] flash_be;
    logic [10:0] sram_addr;
    logic [14:0] flash_addr;
    logic [15:0] flash_wdata, flash_rdata, csr_addr;
    int num_errors = 0, n_compared = 0;

    always #10 clk = ~clk;

    memory_map_remap_decoder u_dut (.*);
    mem_far_side u_mem (.*);

    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk

    // One bus transfer; lat counts edges from taking to ready, 0 skips
    task automatic acc(logic w, logic [1:0] sz, logic [31:0] a, d, int lat);
        int n;
        n = 0;
        bus_req = 1;
        bus_write = w;
        bus_size = sz;
        bus_addr = a;
        bus_wdata = d;
        do
        begin
            @(posedge clk);
            #2;
            n++;
        end while (bus_ready !== 1'b1 && n < 20);
        if (lat != 0)
            chk("latency", lat, n);
        chk("ready", 1, bus_ready);
        rd = bus_rdata;
        flt = bus_fault;
        @(posedge clk);
        #2;
        bus_req = 0;
        @(posedge clk);
        #2;
    endtask : acc

    task automatic t_sram;
        acc(1, SIZE_BYTE, SRAM_BASE + 4, 32'h0000_0011, 4);
        acc(1, SIZE_BYTE, SRAM_BASE + 5, 32'h0000_0022, 4);
        acc(1, SIZE_HALF, SRAM_BASE + 6, 32'h0000_4433, 4);
        acc(0, SIZE_WORD, SRAM_BASE + 4, 0, 4);
        chk("sram word", 32'h4433_2211, rd);
        acc(0, SIZE_HALF, SRAM_BASE + 6, 0, 4);
        chk("sram half", 32'h0000_4433, rd);
        acc(0, SIZE_BYTE, SRAM_BASE + 5, 0, 4);
        chk("sram byte", 32'h0000_0022, rd);
    endtask : t_sram

    task automatic t_flash;
        acc(1, SIZE_WORD, FLASH_BASE + 32'h1C, 32'hCAFE_BABE, 0);
        acc(0, SIZE_WORD, FLASH_BASE + 32'h1C, 0, 7);
        chk("flash word", 32'hCAFE_BABE, rd);
        acc(0, SIZE_WORD, FAST_IRQ_VEC, 0, 7);
        chk("mirror vector", 32'hCAFE_BABE, rd);
        acc(0, SIZE_HALF, FLASH_BASE + 32'h1E, 0, 4);
        chk("flash half", 32'h0000_CAFE, rd);
        acc(1, SIZE_WORD, FLASH_BASE + FLASH_USER, 32'h1, 2);
        chk("boot write fault", 1, flt);
        acc(1, SIZE_HALF, ZERO_BASE + FLASH_USER, 32'h1, 2);
        chk("mirror boot fault", 1, flt);
        acc(0, SIZE_WORD, FLASH_BASE + FLASH_USER, 0, 7);
        chk("boot read fault", 0, flt);
    endtask : t_flash

    task automatic t_space;
        acc(1, SIZE_WORD, 32'h0040_0000, 32'hFFFF_FFFF, 4);
        acc(0, SIZE_WORD, 32'h0040_0000, 0, 4);
        chk("unmapped data", 0, rd);
        chk("unmapped fault", 1, flt);
        acc(1, SIZE_WORD, CSR_BASE + CSR_PAGE + 32'h10, 32'hA5A5_0F0F, 4);
        acc(0, SIZE_WORD, CSR_BASE + CSR_PAGE + 32'h10, 0, 4);
        chk("register word", 32'hA5A5_0F0F, rd);
        chk("register fault", 0, flt);
    endtask : t_space

    task automatic t_remap;
        chk("remap at reset", 1, remap_flash);
        acc(0, SIZE_WORD, REMAP_ADDR, 0, 4);
        chk("remap read", 1, rd);
        acc(1, SIZE_WORD, SRAM_BASE + 32'h1C, 32'h0BAD_F00D, 4);
        acc(1, SIZE_WORD, REMAP_ADDR, 0, 4);
        chk("remap cleared", 0, remap_flash);
        acc(0, SIZE_WORD, REMAP_ADDR, 0, 4);
        chk("remap read back", 0, rd);
        acc(0, SIZE_WORD, FAST_IRQ_VEC, 0, 4);
        chk("sram vector", 32'h0BAD_F00D, rd);
        acc(0, SIZE_WORD, ZERO_BASE + SRAM_SPAN, 0, 4);
        chk("past sram at zero", 1, flt);
        rst_n = 0;
        repeat (2) @(posedge clk);
        #2;
        chk("remap after reset", 1, remap_flash);
        rst_n = 1;
        @(posedge clk);
        #2;
        acc(0, SIZE_WORD, FAST_IRQ_VEC, 0, 7);
        chk("vector after reset", 32'hCAFE_BABE, rd);
    endtask : t_remap

    // Watchdog: the whole run needs well under 2000 cycles
    initial
    begin
        #(20 * 5000);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        #2;
        rst_n = 1;
        @(posedge clk);
        #2;
        t_sram();
        t_flash();
        t_space();
        t_remap();
        tally_and_finish();
    end
endmodule : memory_map_remap_decoder_test

bind memory_map_remap_decoder memory_map_checker u_checker (.*);
